//--- common/mbs_pkg.sv
// package: constants and types of the motion board status block
`default_nettype none
package mbs_pkg;
   localparam int NAX = 4;
   // --------------------------------------------------------------
   // register indices on the plain port
   // --------------------------------------------------------------
   localparam logic [3:0] ADR_CMD = 4'h0;
   localparam logic [3:0] ADR_ARG = 4'h1;
   localparam logic [3:0] ADR_CSR = 4'h2;
   localparam logic [3:0] ADR_RES = 4'h3;
   localparam logic [3:0] ADR_AX0 = 4'h4;
   // --------------------------------------------------------------
   // command codes
   // --------------------------------------------------------------
   localparam logic [7:0] C_KILL   = 8'h01;
   localparam logic [7:0] C_STOP   = 8'h02;
   localparam logic [7:0] C_STOPMD = 8'h03;
   localparam logic [7:0] C_RDAX   = 8'h04;
   localparam logic [7:0] C_RDPOS  = 8'h05;
   localparam logic [7:0] C_RDVEL  = 8'h06;
   localparam logic [7:0] C_IOFN   = 8'h07;
   localparam logic [7:0] C_RDCSR  = 8'h08;
   localparam logic [7:0] C_RDADC  = 8'h09;
   localparam logic [7:0] C_MODE   = 8'h10;
   localparam logic [7:0] C_DIR    = 8'h11;
   localparam logic [7:0] C_TGT    = 8'h12;
   localparam logic [7:0] C_HOME   = 8'h13;
   localparam logic [7:0] C_INDEX  = 8'h14;
   localparam logic [7:0] C_START  = 8'h15;
   localparam logic [7:0] C_MSTART = 8'h16;
   localparam logic [7:0] C_BKTIME = 8'h17;
   localparam logic [7:0] C_BKPOS  = 8'h18;
   localparam logic [7:0] C_RSTPOS = 8'h19;
   // --------------------------------------------------------------
   // analog channel range and reset values
   // --------------------------------------------------------------
   localparam logic [15:0] ADC_LO  = 16'h0001;
   localparam logic [15:0] ADC_HI  = 16'h0008;
   localparam logic        PWR_RST = 1'b1;
   // --------------------------------------------------------------
   // types
   // --------------------------------------------------------------
   typedef struct packed {
      logic running;
      logic prof_done;
      logic pos_err;
      logic wrap_err;
      logic index_found;
      logic motor_off;
      logic home_sw;
      logic fwd_lim;
      logic rev_lim;
      logic lim_en;
      logic trig_en;
      logic homing;
      logic move_fwd;
      logic accel_high;
      logic short_move;
      logic bk_rel;
      logic bk_at_pos;
      logic bk_zero;
   } mbs_axin_t;
   typedef struct packed {
      logic [7:0]  code;
      logic [1:0]  axis;
      logic [15:0] arg;
   } mbs_cmd_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } mbs_state_t;
   typedef struct packed {
      mbs_state_t     fsm;
      mbs_cmd_t       cmd;
      logic [NAX-1:0] vel;
      logic [NAX-1:0] fwd;
      logic [NAX-1:0] notex;
      logic           last;
      logic           ferr;
      logic           pwr;
      logic           pend;
      logic           hwf;
      logic [15:0]    res;
      logic [15:0]    rdata;
      logic           ex;
      mbs_cmd_t       excmd;
   } mbs_st_t;
endpackage : mbs_pkg
`default_nettype wire

//--- hw/mbs_status.sv
// module: status words and command legality checking of a motion board
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mbs_status
   import mbs_pkg::*;
(
   // clock and reset
   input  wire logic                 i_core_clk,
   input  wire logic                 i_arst_n,
   // register port
   input  wire logic [3:0]           i_addr,
   input  wire logic [15:0]          i_wdata,
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   output logic      [15:0]          o_rdata,
   // axis and board conditions
   input  wire mbs_axin_t [NAX-1:0]  i_axis,
   input  wire logic [7:0][7:0]      i_adc,
   input  wire logic                 i_watchdog,
   input  wire logic                 i_hw_fail,
   // accepted commands to the motion engine
   output logic                      o_exec,
   output mbs_cmd_t                  o_exec_cmd
);
   // --------------------------------------------------------------
   // state and per-axis views
   // --------------------------------------------------------------
   mbs_st_t                  s_reg;
   mbs_st_t                  s_next;
   logic [NAX-1:0][15:0]     ax_word;
   logic [NAX-1:0]           blocked;
   logic [NAX-1:0]           home_bad;
   logic [NAX-1:0]           idx_bad;
   logic [NAX-1:0]           tbk_bad;
   logic [NAX-1:0]           pbk_bad;
   logic [NAX-1:0]           homing;
   logic [15:0]              csr;
   logic                     any_home;
   logic                     home_ok;
   logic [2:0]               adc_ix;

   generate
      for (genvar a = 0; a < NAX; a++) begin : g_ax
         logic dir;
         assign dir = s_reg.vel[a] ? s_reg.fwd[a] : i_axis[a].move_fwd;
         assign ax_word[a] = {2'b00, s_reg.notex[a], s_reg.fwd[a],
            s_reg.vel[a], i_axis[a].prof_done, 2'b00,
            i_axis[a].running, 1'b0, i_axis[a].pos_err,
            i_axis[a].wrap_err, i_axis[a].index_found,
            i_axis[a].motor_off, i_axis[a].home_sw,
            i_axis[a].fwd_lim | i_axis[a].rev_lim};
         assign blocked[a] = dir ? i_axis[a].fwd_lim
                                 : i_axis[a].rev_lim;
         assign home_bad[a] = i_axis[a].homing | ~i_axis[a].lim_en |
            i_axis[a].trig_en |
            (i_axis[a].fwd_lim & i_axis[a].rev_lim);
         // home switch alone does not block
         assign idx_bad[a] = i_axis[a].running | i_axis[a].trig_en |
            i_axis[a].fwd_lim | i_axis[a].rev_lim;
         assign tbk_bad[a] = s_reg.vel[a] | i_axis[a].accel_high |
            i_axis[a].short_move;
         assign pbk_bad[a] = i_axis[a].bk_rel ? i_axis[a].bk_zero
                                              : i_axis[a].bk_at_pos;
         assign homing[a] = i_axis[a].homing;
      end
   endgenerate

   // --------------------------------------------------------------
   // board word
   // --------------------------------------------------------------
   always_comb begin
      csr = 16'h0000;
      for (int a = 0; a < NAX; a++) begin
         csr[12+a] = i_axis[a].prof_done;
         csr[8+a]  = i_axis[a].running;
      end
      csr[7] = s_reg.last;
      csr[6] = s_reg.hwf;
      csr[5] = s_reg.pwr;
      csr[4] = s_reg.ferr;
      csr[3] = s_reg.fsm == ST_EXEC;
      csr[1] = s_reg.pend;
      csr[0] = s_reg.fsm == ST_IDLE;
   end

   assign any_home = |homing;
   assign home_ok = s_reg.cmd.code inside {C_KILL, C_STOP, C_STOPMD,
      C_RDAX, C_RDPOS, C_RDVEL, C_IOFN, C_RDCSR, C_RDADC};

   assign adc_ix = (s_reg.cmd.arg < ADC_LO) ? 3'h0 :
                   (s_reg.cmd.arg > ADC_HI) ? 3'h7 :
                   3'(s_reg.cmd.arg - ADC_LO);

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      logic           bad;
      logic           ferr;
      logic [NAX-1:0] amask;
      logic [NAX-1:0] ill;
      bad    = 1'b0;
      ferr   = 1'b0;
      amask  = 4'h1 << s_reg.cmd.axis;
      ill    = 4'h0;
      s_next = s_reg;
      s_next.ex  = 1'b0;
      s_next.hwf = i_hw_fail;
      s_next.rdata = 16'h0000;
      if (i_rd) begin
         unique case (i_addr)
            ADR_CMD: s_next.rdata = {6'h00, s_reg.cmd.axis,
                                     s_reg.cmd.code};
            ADR_ARG: s_next.rdata = s_reg.cmd.arg;
            ADR_CSR: s_next.rdata = csr;
            ADR_RES: s_next.rdata = s_reg.res;
            4'h4, 4'h5, 4'h6, 4'h7:
               s_next.rdata = ax_word[i_addr[1:0]];
            default: s_next.rdata = 16'h0000;
         endcase
      end
      // reading the result empties the buffer; a new result wins
      if (i_rd && i_addr == ADR_RES) begin
         s_next.pend = 1'b0;
      end
      if (i_wr && i_addr == ADR_ARG && s_reg.fsm == ST_IDLE) begin
         s_next.cmd.arg = i_wdata;
      end
      // commands written while busy are dropped; ready shows why
      if (i_wr && i_addr == ADR_CMD && s_reg.fsm == ST_IDLE) begin
         s_next.cmd.code = i_wdata[7:0];
         s_next.cmd.axis = i_wdata[9:8];
         s_next.fsm      = ST_EXEC;
      end
      if (s_reg.fsm == ST_EXEC) begin
         if (any_home && !home_ok) begin
            bad = 1'b1;
         end else begin
            unique case (s_reg.cmd.code)
               C_KILL, C_STOP, C_STOPMD, C_RDPOS, C_RDVEL,
               C_IOFN: bad = 1'b0;
               C_MODE: s_next.vel[s_reg.cmd.axis] = s_reg.cmd.arg[0];
               C_DIR: begin
                  bad = ~s_reg.vel[s_reg.cmd.axis];
                  if (!bad) begin
                     s_next.fwd[s_reg.cmd.axis] = s_reg.cmd.arg[0];
                  end
               end
               C_TGT:   bad = s_reg.vel[s_reg.cmd.axis];
               C_HOME:  bad = home_bad[s_reg.cmd.axis];
               C_INDEX: bad = idx_bad[s_reg.cmd.axis];
               C_START: bad = blocked[s_reg.cmd.axis];
               // multi start needs two axes, none blocked
               C_MSTART: begin
                  amask = s_reg.cmd.arg[NAX-1:0];
                  if ($countones(amask) < 2) begin
                     ferr = 1'b1;
                  end
                  ill = amask & blocked;
               end
               C_BKTIME: bad = tbk_bad[s_reg.cmd.axis];
               C_BKPOS:  bad = pbk_bad[s_reg.cmd.axis];
               // reset position clears the reset flag
               C_RSTPOS: s_next.pwr = 1'b0;
               C_RDAX: begin
                  s_next.res  = ax_word[s_reg.cmd.axis];
                  s_next.pend = 1'b1;
               end
               C_RDCSR: begin
                  s_next.res  = csr;
                  s_next.pend = 1'b1;
               end
               C_RDADC: begin
                  s_next.res  = {8'h00, i_adc[adc_ix]};
                  s_next.pend = 1'b1;
               end
               default: ferr = 1'b1;
            endcase
         end
         if (bad) begin
            ill = amask;
         end
         // flag the refused axes, else clear all involved axes
         if (!ferr) begin
            s_next.notex = (|ill) ? (s_reg.notex | ill)
                                  : (s_reg.notex & ~amask);
         end
         // flags land with the busy drop
         s_next.last  = ~(|ill);
         s_next.ferr  = ferr;
         s_next.ex    = ~ferr & ~(|ill);
         s_next.excmd = s_reg.cmd;
         s_next.fsm   = ST_IDLE;
      end
      // watchdog set wins over the clear
      if (i_watchdog) begin
         s_next.pwr = 1'b1;
      end
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   // single clock, all flags registered once
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_reg       <= '0;
         s_reg.fsm   <= ST_IDLE;
         s_reg.last  <= 1'b1;
         s_reg.pwr   <= PWR_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_rdata    = s_reg.rdata;
   assign o_exec     = s_reg.ex;
   assign o_exec_cmd = s_reg.excmd;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   adc_clamp_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_RDADC &&
       s_reg.cmd.arg > ADC_HI && !any_home)
      |=> s_reg.res == {8'h00, $past(i_adc[7])})
      else $error("channel above range not clamped to last");

   adc_width_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_RDADC)
      |=> s_reg.res[15:8] == 8'h00 && s_reg.pend)
      else $error("analog result high byte not zero");

   dir_illegal_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_DIR &&
       !s_reg.vel[s_reg.cmd.axis])
      |=> s_reg.notex[$past(s_reg.cmd.axis)] && !s_reg.last)
      else $error("direction in position mode not flagged");

   home_block_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_HOME &&
       i_axis[s_reg.cmd.axis].fwd_lim &&
       i_axis[s_reg.cmd.axis].rev_lim)
      |=> !s_reg.last && !o_exec)
      else $error("find home with both limits accepted");

   index_ok_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_INDEX &&
       !any_home && !idx_bad[s_reg.cmd.axis])
      |=> o_exec && !s_reg.notex[$past(s_reg.cmd.axis)])
      else $error("legal find index refused");

   multi_err_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_MSTART &&
       !any_home && $countones(s_reg.cmd.arg[NAX-1:0]) == 1)
      |=> s_reg.ferr && !o_exec)
      else $error("single axis multi start not an error");

   home_lock_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && any_home && s_reg.cmd.code == C_TGT)
      |=> !s_reg.last ##1 s_reg.notex[$past(s_reg.cmd.axis, 2)])
      else $error("command during home search not flagged");

   busy_seq_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_wr && i_addr == ADR_CMD && s_reg.fsm == ST_IDLE)
      |=> csr[3] && !csr[0] ##1 !csr[3] && csr[0])
      else $error("busy not exactly one cycle");

   pwr_clear_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_RSTPOS &&
       !any_home && !i_watchdog) |=> !csr[5])
      else $error("reset flag not cleared by reset position");

   pend_keep_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.pend && !(i_rd && i_addr == ADR_RES)) |=> csr[1])
      else $error("pending result lost without a read");

   tgt_illegal_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_TGT &&
       s_reg.vel[s_reg.cmd.axis])
      |=> s_reg.notex[$past(s_reg.cmd.axis)] && !s_reg.last)
      else $error("target load in velocity mode not flagged");

   start_block_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_START &&
       blocked[s_reg.cmd.axis])
      |=> !o_exec && !s_reg.last)
      else $error("start into an active limit accepted");

   tbreak_block_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_BKTIME &&
       (s_reg.vel[s_reg.cmd.axis] || i_axis[s_reg.cmd.axis].short_move))
      |=> !o_exec && !s_reg.last)
      else $error("time breakpoint accepted in a refused case");

   pbreak_block_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_BKPOS &&
       i_axis[s_reg.cmd.axis].bk_rel && i_axis[s_reg.cmd.axis].bk_zero)
      |=> !o_exec && !s_reg.last)
      else $error("zero relative breakpoint accepted");

   kill_clear_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_KILL)
      |=> o_exec && !s_reg.notex[$past(s_reg.cmd.axis)])
      else $error("accepted command left not-executed flag set");

   dir_set_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_DIR && !any_home &&
       s_reg.vel[s_reg.cmd.axis])
      |=> ax_word[$past(s_reg.cmd.axis)][12] == $past(s_reg.cmd.arg[0]))
      else $error("direction bit not taken from command");

   mode_set_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (s_reg.fsm == ST_EXEC && s_reg.cmd.code == C_MODE && !any_home)
      |=> ax_word[$past(s_reg.cmd.axis)][11] == $past(s_reg.cmd.arg[0]))
      else $error("mode bit not taken from command");

   unused_zero_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      !csr[2] && ((ax_word[0] | ax_word[1] | ax_word[2] | ax_word[3]) &
       16'hC340) == 16'h0000)
      else $error("unused status bit not zero");

   rd_idle_a: assert property (
      @(posedge i_core_clk) disable iff (!i_arst_n)
      !i_rd |=> o_rdata == 16'h0000)
      else $error("read data outside the read answer cycle");
endmodule : mbs_status
`default_nettype wire

//--- tb/mbs_host.sv
// host model: register-port master that writes and reads the board
`timescale 1ns/1ps
`default_nettype none
module mbs_host (
   // clock
   input  wire logic        i_clk,
   // register port
   input  wire logic [15:0] i_rdata,
   output logic      [3:0]  o_addr,
   output logic      [15:0] o_wdata,
   output logic             o_wr,
   output logic             o_rd
);
   // ---------------------------------------------------------------
   // bus cycles
   // ---------------------------------------------------------------
   initial begin
      o_addr = 4'h0;
      o_wdata = 16'h0000;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // data inverted after the strobe so a stale word never looks valid
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      // answer stands one cycle; taken at the edge that ends it
      @(posedge i_clk);
      d = i_rdata;
   endtask : rd
endmodule : mbs_host
`default_nettype wire

//--- tb/mbs_status_tb.sv
// testbench: status words and command legality of the motion board block
`timescale 1ns/1ps
`default_nettype none
module mbs_status_tb;
   import mbs_pkg::*;
   // ---------------------------------------------------------------
   // signals and table
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  c;
      logic        a;
      logic [17:0] f;
      logic        ok;
   } mbs_row_t;
   localparam logic [17:0] RUN = 18'h20000, PD = 18'h10000, ST = 18'h0F800,
      HS = 18'h00800, FL = 18'h00400, RL = 18'h00200, LE = 18'h00100,
      TR = 18'h00080, HM = 18'h00040, MF = 18'h00020, AH = 18'h00010,
      SM = 18'h00008, BR = 18'h00004, BA = 18'h00002, BZ = 18'h00001;
   logic                i_core_clk = 1'b0;
   logic                i_arst_n = 1'b0;
   logic [3:0]          addr;
   logic [15:0]         wdata;
   logic                wr;
   logic                rd;
   logic [15:0]         rdata;
   mbs_axin_t [NAX-1:0] axis = '0;
   logic [7:0][7:0]     adc = 64'hFF77_6655_4433_2211;
   logic                wd = 1'b0;
   logic                hwf = 1'b0;
   logic                ex;
   mbs_cmd_t            excmd;
   int                  failures = 0;
   int                  check_count = 0;
   int                  ch;
   logic                vel = 1'b0;
   logic                fwd = 1'b0;
   logic                pwr = 1'b1;
   logic                pend = 1'b0;
   logic [15:0]         v;
   logic                e;
   mbs_row_t            r;
   mbs_row_t rows [41] = '{
      {C_MODE, 1'b1, LE, 1'b1}, {C_TGT, 1'b0, LE, 1'b0},
      {C_DIR, 1'b1, LE, 1'b1}, {C_BKTIME, 1'b0, LE, 1'b0},
      {C_MODE, 1'b0, LE, 1'b1}, {C_DIR, 1'b0, LE, 1'b0},
      {C_TGT, 1'b0, LE, 1'b1}, {C_HOME, 1'b0, 18'h0, 1'b0},
      {C_HOME, 1'b0, LE|TR, 1'b0}, {C_HOME, 1'b0, LE|FL|RL, 1'b0},
      {C_HOME, 1'b0, LE|HM, 1'b0}, {C_HOME, 1'b0, LE|RL, 1'b1},
      {C_INDEX, 1'b0, LE|RUN, 1'b0}, {C_INDEX, 1'b0, LE|TR, 1'b0},
      {C_INDEX, 1'b0, LE|RL, 1'b0}, {C_INDEX, 1'b0, LE|HS, 1'b1},
      {C_START, 1'b0, LE|FL|MF, 1'b0}, {C_START, 1'b0, LE|FL, 1'b1},
      {C_START, 1'b0, LE|RL, 1'b0}, {C_BKTIME, 1'b0, LE|AH, 1'b0},
      {C_BKTIME, 1'b0, LE|SM, 1'b0}, {C_BKTIME, 1'b0, LE, 1'b1},
      {C_BKPOS, 1'b0, LE|BA, 1'b0}, {C_BKPOS, 1'b0, LE|BR|BZ, 1'b0},
      {C_BKPOS, 1'b0, LE|BR|BA, 1'b1}, {C_BKPOS, 1'b0, LE|BZ, 1'b1},
      {C_KILL, 1'b0, LE|HM, 1'b1}, {C_STOP, 1'b0, LE|HM, 1'b1},
      {C_STOPMD, 1'b0, LE|HM, 1'b1}, {C_RDAX, 1'b0, LE|HM, 1'b1},
      {C_RDPOS, 1'b0, LE|HM, 1'b1}, {C_RDVEL, 1'b0, LE|HM, 1'b1},
      {C_IOFN, 1'b0, LE|HM, 1'b1}, {C_RDCSR, 1'b0, LE|HM, 1'b1},
      {C_RDADC, 1'b0, LE|HM, 1'b1}, {C_TGT, 1'b0, LE|HM, 1'b0},
      {C_START, 1'b0, LE|HM, 1'b0}, {C_RSTPOS, 1'b0, LE|HM, 1'b0},
      {C_MODE, 1'b1, LE|HM, 1'b0}, {C_RSTPOS, 1'b0, LE, 1'b1},
      {C_KILL, 1'b0, RUN|PD|ST|FL, 1'b1}};
   always #25 i_core_clk = ~i_core_clk;
   // ---------------------------------------------------------------
   // instances
   // ---------------------------------------------------------------
   mbs_host host (.i_clk(i_core_clk), .i_rdata(rdata), .o_addr(addr),
      .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
   mbs_status dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_axis(axis), .i_adc(adc), .i_watchdog(wd), .i_hw_fail(hwf),
      .o_exec(ex), .o_exec_cmd(excmd));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [15:0] x,
                      input logic [15:0] g);
      check_count++;
      if (g !== x) begin
         failures++;
         $display("BAD %s exp %h got %h", n, x, g);
      end
   endtask : chk
   // argument first: the command write starts the check
   task automatic cmd(input logic [7:0] c, input logic [15:0] a);
      host.wr(ADR_ARG, a);
      host.wr(ADR_CMD, {6'h0, 2'd0, c});
      @(posedge i_core_clk);
      @(posedge i_core_clk);
      // exec pulse still stands before this edge updates it
      e = ex;
   endtask : cmd
   function automatic logic [15:0] csr_exp(input logic ok, input logic fe);
      csr_exp = {8'h0, ok, hwf, pwr, fe, 2'b0, pend, 1'b1};
      for (int k = 0; k < NAX; k++) begin
         csr_exp[12+k] = axis[k].prof_done;
         csr_exp[8+k] = axis[k].running;
      end
   endfunction : csr_exp
   // direction bit only meaningful in velocity mode, so masked otherwise
   task automatic rd_ax(input int k, input logic nx);
      mbs_axin_t a;
      logic      vm;
      a = axis[k];
      vm = (k == 0) && vel;
      host.rd(ADR_AX0 + 4'(k), v);
      if (!vm) v[12] = 1'b0;
      chk("axis word", {2'b0, nx, vm & fwd, vm, a.prof_done, 2'b0,
         a.running, 1'b0, a.pos_err, a.wrap_err, a.index_found,
         a.motor_off, a.home_sw, a.fwd_lim | a.rev_lim}, v);
   endtask : rd_ax
   task automatic close_out();
      if (failures == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      #2000000;
      failures++;
      close_out();
   end
   initial begin
      repeat (8) @(posedge i_core_clk);
      i_arst_n <= 1'b1;
      host.rd(ADR_CSR, v);
      chk("reset word", csr_exp(1'b1, 1'b0), v);
      for (int k = 0; k < NAX; k++) rd_ax(k, 1'b0);
      host.rd(4'hF, v);
      chk("unmapped", 16'h0, v);
      for (int i = 0; i < 41; i++) begin
         r = rows[i];
         axis[0] <= mbs_axin_t'(r.f);
         cmd(r.c, {15'h0, r.a});
         chk("exec", {15'h0, r.ok}, {15'h0, e});
         chk("exec code", {8'h0, r.c}, {8'h0, excmd.code});
         chk("exec arg", {15'h0, r.a}, excmd.arg);
         if (r.ok && r.c == C_MODE) vel = r.a;
         if (r.ok && r.c == C_DIR) fwd = r.a;
         if (r.ok && r.c == C_RSTPOS) pwr = 1'b0;
         if (r.ok && (r.c == C_RDAX || r.c == C_RDCSR || r.c == C_RDADC))
            pend = 1'b1;
         host.rd(ADR_CSR, v);
         chk("board word", csr_exp(r.ok, 1'b0), v);
         rd_ax(0, !r.ok);
      end
      host.rd(ADR_CMD, v);
      chk("command echo", {8'h0, C_KILL}, v);
      host.rd(ADR_ARG, v);
      chk("argument echo", 16'h0, v);
      axis[0] <= mbs_axin_t'(LE);
      for (int k = 0; k < 10; k++) begin
         cmd(C_RDADC, 16'(k));
         host.rd(ADR_CSR, v);
         chk("pending set", 16'h1, {15'h0, v[1]});
         host.rd(ADR_RES, v);
         ch = (k < 1) ? 0 : (k > 8) ? 7 : k - 1;
         chk("analog", {8'h0, adc[ch]}, v);
         host.rd(ADR_CSR, v);
         chk("pending clear", 16'h0, {15'h0, v[1]});
      end
      pend = 1'b0;
      axis[2] <= mbs_axin_t'(RUN | PD | ST | RL);
      hwf <= 1'b1;
      @(posedge i_core_clk);
      @(posedge i_core_clk);
      rd_ax(2, 1'b0);
      host.rd(ADR_CSR, v);
      chk("board word", csr_exp(1'b1, 1'b0), v);
      wd <= 1'b1;
      @(posedge i_core_clk);
      wd <= 1'b0;
      pwr = 1'b1;
      host.rd(ADR_CSR, v);
      chk("watchdog", csr_exp(1'b1, 1'b0), v);
      cmd(8'h7F, 16'h0);
      host.rd(ADR_CSR, v);
      chk("bad code", csr_exp(1'b1, 1'b1), v);
      cmd(C_MSTART, 16'h0001);
      host.rd(ADR_CSR, v);
      chk("one axis start", csr_exp(1'b1, 1'b1), v);
      axis[1] <= mbs_axin_t'(LE | FL | MF);
      cmd(C_MSTART, 16'h0003);
      chk("exec", 16'h0, {15'h0, e});
      host.rd(ADR_CSR, v);
      chk("board word", csr_exp(1'b0, 1'b0), v);
      rd_ax(1, 1'b1);
      // mid-run reset: flags, modes and pending data all return home
      i_arst_n <= 1'b0;
      vel = 1'b0;
      fwd = 1'b0;
      pwr = 1'b1;
      @(posedge i_core_clk);
      chk("reset rdata", 16'h0, rdata);
      chk("reset exec", 16'h0, {15'h0, ex});
      @(posedge i_core_clk);
      i_arst_n <= 1'b1;
      host.rd(ADR_CSR, v);
      chk("rerun word", csr_exp(1'b1, 1'b0), v);
      rd_ax(1, 1'b0);
      close_out();
   end
endmodule : mbs_status_tb
`default_nettype wire
